// >>> hdl/sci_serial.sv
`timescale 1ns/1ps
// Function
// - two independent channels, own config and buffers
// - channel zero also carries monitor/download path
// - eleven fixed baud rates, 2400 to 230400
// - protocol byte selects width, stop, parity
// - values 3/19/27 and 2/18/26 decode correctly
// - buffer depths configurable up to 1024 bytes
// - channel one raises event on byte arrival
// - no new event while one is serviced
// - event refires after service if data remains
// - baud and protocol changeable while running
// - transmitter drains its buffer on its own
// - write to full transmit buffer drops byte

// =====================================================
// fifo with a run-time fill limit below its physical depth
module sci_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [10:0] limit,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady,
  output logic [10:0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // storage words
  logic [AW-1:0] wrPtr; // next slot to write
  logic [AW-1:0] rdPtr; // oldest slot
  logic doWr;
  logic doRd;
  // full at the configured depth or the physical one, whichever is less
  assign inReady = (count < limit) && (count < 11'(DEPTH));
  assign outValid = (count != 11'h000);
  assign outData = mem[rdPtr];
  assign doWr = inValid && inReady;
  assign doRd = outValid && outReady;

  // storage write
  always_ff @(posedge sys_clk) begin
    if (doWr) begin
      mem[wrPtr] <= inData;
    end
  end

  // pointers and fill count
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= 11'h000;
    end else begin
      if (doWr) begin
        wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + AW'(1);
      end
      if (doRd) begin
        rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + AW'(1);
      end
      count <= count + 11'(doWr) - 11'(doRd);
    end
  end
endmodule

// =====================================================
// one serial channel: config, buffers, transmitter, receiver
module sci_channel #(
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic cfgApply,
  input wire logic [3:0] cfgBaud,
  input wire logic [7:0] cfgProto,
  input wire logic [10:0] cfgRxDepth,
  input wire logic [10:0] cfgTxDepth,
  output logic cfgDone,
  input wire logic txValid,
  input wire logic [7:0] txData,
  output logic txReady,
  output logic txDrop,
  output logic [10:0] txFree,
  output logic rxValid,
  output logic [7:0] rxData,
  input wire logic rxReady,
  output logic [10:0] rxCount,
  output logic rxArrive,
  output logic rxError,
  input wire logic serialIn,
  output logic serialOut
);
  typedef enum logic [2:0] {SCI_IDLE, SCI_START, SCI_DATA, SCI_PAR, SCI_STOP} sci_state_t;
  sci_state_t txState; // transmitter state
  sci_state_t rxState; // receiver state
  logic [16:0] bitDiv; // cycles per bit
  logic [3:0] nBits; // data bits per frame
  logic twoStop; // two stop bits
  logic [1:0] parMode; // parity mode
  logic [10:0] rxLim; // receive depth limit
  logic [10:0] txLim; // transmit depth limit
  logic txOutValid;
  logic [7:0] txOutData;
  logic txOutReady;
  logic [10:0] txCount;
  logic [16:0] txTmr; // transmit bit timer
  logic [7:0] txShift; // bits still to send
  logic [3:0] txIdx; // bit index within data or stop
  logic txPar; // running parity
  logic [16:0] rxTmr; // receive sample timer
  logic [7:0] rxShift; // collected data bits
  logic [3:0] rxIdx;
  logic rxPar;
  logic rxPush; // good byte into buffer
  logic rxPushReady;
  logic txTick;
  logic rxTick;

  // =====================================================
  // configuration, latched on apply; a later apply retunes live
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bitDiv <= sci_pkg::sci_bit_div(sci_pkg::SCI_RST_BAUD);
      nBits <= 4'h8;
      twoStop <= 1'b0;
      parMode <= 2'h0;
      rxLim <= 11'h000;
      txLim <= 11'h000;
      cfgDone <= 1'b0;
    end else if (cfgApply) begin
      bitDiv <= sci_pkg::sci_bit_div(cfgBaud);
      nBits <= 4'h5 + {2'h0, cfgProto[sci_pkg::SCI_P_BITS_LO +: 2]};
      twoStop <= cfgProto[sci_pkg::SCI_P_STOP];
      parMode <= cfgProto[sci_pkg::SCI_P_PAR_LO +: 2];
      // depths are clipped to the maximum; physical depth clips further
      rxLim <= (cfgRxDepth > sci_pkg::SCI_MAX_DEPTH) ? sci_pkg::SCI_MAX_DEPTH : cfgRxDepth;
      txLim <= (cfgTxDepth > sci_pkg::SCI_MAX_DEPTH) ? sci_pkg::SCI_MAX_DEPTH : cfgTxDepth;
      cfgDone <= 1'b1;
    end
  end

  // =====================================================
  // transmit buffer; a write that does not fit is dropped, never stalled
  sci_fifo #(.WIDTH(8), .DEPTH(DEPTH)) txFifo (
    .sys_clk(sys_clk), .reset(reset), .limit(txLim),
    .inValid(txValid), .inData(txData), .inReady(txReady),
    .outValid(txOutValid), .outData(txOutData), .outReady(txOutReady),
    .count(txCount)
  );
  assign txDrop = txValid && !txReady;
  // free space against the smaller of the two limits
  assign txFree = ((txLim < 11'(DEPTH)) ? txLim : 11'(DEPTH)) - txCount;
  assign txOutReady = (txState == SCI_IDLE) && cfgDone;
  assign txTick = (txTmr == bitDiv - 17'h00001);

  // transmitter: pulls one byte whenever idle until the buffer empties
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      txState <= SCI_IDLE;
      serialOut <= 1'b1;
      txTmr <= '0;
      txShift <= 8'h00;
      txIdx <= 4'h0;
      txPar <= 1'b0;
    end else begin
      txTmr <= (txState == SCI_IDLE || txTick) ? 17'h00000 : txTmr + 17'h00001;
      unique case (txState)
        SCI_IDLE: begin
          serialOut <= 1'b1; // idle line high
          if (txOutValid && txOutReady) begin
            serialOut <= 1'b0;
            txShift <= txOutData;
            txPar <= (parMode == sci_pkg::SCI_PAR_ODD);
            txIdx <= 4'h0;
            txState <= SCI_START;
          end
        end
        SCI_START, SCI_DATA: begin
          if (txTick) begin
            if (txState == SCI_DATA && txIdx == nBits) begin
              // parity only for even or odd; reserved code sends none
              if (parMode[1]) begin
                serialOut <= txPar;
                txState <= SCI_PAR;
              end else begin
                serialOut <= 1'b1;
                txIdx <= 4'h0;
                txState <= SCI_STOP;
              end
            end else begin
              serialOut <= txShift[0];
              txShift <= {1'b0, txShift[7:1]};
              txPar <= txPar ^ txShift[0];
              txIdx <= txIdx + 4'h1;
              txState <= SCI_DATA;
            end
          end
        end
        SCI_PAR: begin
          if (txTick) begin
            serialOut <= 1'b1;
            txIdx <= 4'h0;
            txState <= SCI_STOP;
          end
        end
        SCI_STOP: begin
          if (txTick) begin
            if (twoStop && txIdx == 4'h0) begin
              txIdx <= 4'h1;
            end else begin
              txState <= SCI_IDLE;
            end
          end
        end
      endcase
    end
  end

  // =====================================================
  // receiver: samples each bit at its middle, first stop bit only
  assign rxTick = (rxTmr == 17'h00000);
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rxState <= SCI_IDLE;
      rxTmr <= '0;
      rxShift <= 8'h00;
      rxIdx <= 4'h0;
      rxPar <= 1'b0;
      rxPush <= 1'b0;
      rxError <= 1'b0;
    end else begin
      rxPush <= 1'b0;
      rxError <= 1'b0;
      rxTmr <= rxTick ? bitDiv - 17'h00001 : rxTmr - 17'h00001;
      unique case (rxState)
        SCI_IDLE: begin
          if (!serialIn && cfgDone) begin
            rxTmr <= {1'b0, bitDiv[16:1]}; // half a bit to the middle
            rxState <= SCI_START;
          end
        end
        SCI_START: begin
          if (rxTick) begin
            // a glitch that is high again at mid-bit is no start
            rxState <= serialIn ? SCI_IDLE : SCI_DATA;
            rxIdx <= 4'h0;
            rxShift <= 8'h00;
            rxPar <= (parMode == sci_pkg::SCI_PAR_ODD);
          end
        end
        SCI_DATA: begin
          if (rxTick) begin
            rxShift[rxIdx[2:0]] <= serialIn;
            rxPar <= rxPar ^ serialIn;
            rxIdx <= rxIdx + 4'h1;
            if (rxIdx + 4'h1 == nBits) begin
              rxState <= parMode[1] ? SCI_PAR : SCI_STOP;
            end
          end
        end
        SCI_PAR: begin
          if (rxTick) begin
            rxPar <= rxPar ^ serialIn;
            rxState <= SCI_STOP;
          end
        end
        SCI_STOP: begin
          if (rxTick) begin
            // bad stop or parity drops the byte and pulses an error
            if (serialIn && !(parMode[1] && rxPar)) begin
              rxPush <= 1'b1;
            end else begin
              rxError <= 1'b1;
            end
            rxState <= SCI_IDLE;
          end
        end
      endcase
    end
  end

  // receive buffer; overrun bytes are lost when the reader falls behind
  sci_fifo #(.WIDTH(8), .DEPTH(DEPTH)) rxFifo (
    .sys_clk(sys_clk), .reset(reset), .limit(rxLim),
    .inValid(rxPush), .inData(rxShift), .inReady(rxPushReady),
    .outValid(rxValid), .outData(rxData), .outReady(rxReady),
    .count(rxCount)
  );
  assign rxArrive = rxPush && rxPushReady;

  // =====================================================
  // checks
  chk_tx_start: assert property (@(posedge sys_clk) disable iff (reset)
    txState == SCI_IDLE && txOutValid && txOutReady |=> !serialOut && txState == SCI_START)
    else $error("start bit not driven low");
  chk_stop_high: assert property (@(posedge sys_clk) disable iff (reset)
    txState == SCI_STOP || txState == SCI_IDLE |-> serialOut)
    else $error("line not high in stop or idle");
  // a refused write must not grow the count; the drain may still shrink it
  chk_full_drop: assert property (@(posedge sys_clk) disable iff (reset)
    txValid && txFree == 11'h000 |-> txDrop && !txReady ##1 txCount <= $past(txCount))
    else $error("write to full buffer not dropped");
  // an idle configured transmitter takes the oldest byte, even with a write alongside
  chk_tx_drain: assert property (@(posedge sys_clk) disable iff (reset)
    txState == SCI_IDLE && txOutValid && cfgDone
    |=> txState == SCI_START && txCount == $past(txCount) - 11'h001
    + {10'h000, $past(txValid) && $past(txReady)})
    else $error("transmitter did not take byte");
  chk_cfg_width: assert property (@(posedge sys_clk) disable iff (reset)
    cfgApply && cfgProto == 8'h1b |=> nBits == 4'h8 && parMode == sci_pkg::SCI_PAR_ODD && !twoStop)
    else $error("protocol 27 misdecoded");
  chk_cfg_baud: assert property (@(posedge sys_clk) disable iff (reset)
    cfgApply && cfgBaud == 4'ha |=> bitDiv == 17'(sci_pkg::SCI_CLK_HZ / 230400))
    else $error("baud divider not retuned");
endmodule

// =====================================================
// top: two channels, monitor path on channel zero, event on channel one
module sci_serial #(
  parameter int NUM_CH = 2,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [NUM_CH-1:0] serial_runtime_reconfigure,
  input wire logic [NUM_CH*4-1:0] cfgBaud,
  input wire logic [NUM_CH*8-1:0] cfgProto,
  input wire logic [NUM_CH*11-1:0] cfgRxDepth,
  input wire logic [NUM_CH*11-1:0] cfgTxDepth,
  output logic [NUM_CH-1:0] cfgDone,
  input wire logic [NUM_CH-1:0] txValid,
  input wire logic [NUM_CH*8-1:0] txData,
  output logic [NUM_CH-1:0] txReady,
  output logic [NUM_CH-1:0] txDrop,
  output logic [NUM_CH*11-1:0] txFree,
  output logic [NUM_CH-1:0] rxValid,
  output logic [NUM_CH*8-1:0] rxData,
  input wire logic [NUM_CH-1:0] rxReady,
  output logic [NUM_CH*11-1:0] rxCount,
  output logic [NUM_CH-1:0] rxError,
  input wire logic monitorMode,
  input wire logic monTxValid,
  input wire logic [7:0] monTxData,
  output logic monRxValid,
  input wire logic monRxReady,
  input wire logic rxEventEnable,
  input wire logic serviceActive,
  output logic rx_arrival_event,
  input wire logic [NUM_CH-1:0] serialIn,
  output logic [NUM_CH-1:0] serialOut
);
  logic [NUM_CH-1:0] chTxValid; // per channel write after monitor mux
  logic [NUM_CH*8-1:0] chTxData;
  logic [NUM_CH-1:0] chRxValid;
  logic [NUM_CH-1:0] chRxReady;
  logic [NUM_CH-1:0] arrive;
  logic pending; // arrival not yet signalled
  logic awaitSvc; // event raised, service not yet begun
  logic svcPrev; // service level one cycle ago

  // channel zero belongs to the monitor while monitorMode is high;
  // the normal txValid, txData, rxValid and rxReady of channel zero are cut off in that mode
  always_comb begin
    chTxValid = txValid;
    chTxData = txData;
    chRxReady = rxReady;
    rxValid = chRxValid;
    chTxValid[0] = monitorMode ? monTxValid : txValid[0];
    chTxData[7:0] = monitorMode ? monTxData : txData[7:0];
    chRxReady[0] = monitorMode ? monRxReady : rxReady[0];
    rxValid[0] = chRxValid[0] && !monitorMode;
  end
  assign monRxValid = chRxValid[0] && monitorMode;

  // one full channel per index
  for (genvar c = 0; c < NUM_CH; c++) begin : gCh
    sci_channel #(.DEPTH(DEPTH)) chan (
      .sys_clk(sys_clk), .reset(reset),
      .cfgApply(serial_runtime_reconfigure[c]), .cfgBaud(cfgBaud[c*4 +: 4]),
      .cfgProto(cfgProto[c*8 +: 8]), .cfgRxDepth(cfgRxDepth[c*11 +: 11]),
      .cfgTxDepth(cfgTxDepth[c*11 +: 11]), .cfgDone(cfgDone[c]),
      .txValid(chTxValid[c]), .txData(chTxData[c*8 +: 8]), .txReady(txReady[c]),
      .txDrop(txDrop[c]), .txFree(txFree[c*11 +: 11]),
      .rxValid(chRxValid[c]), .rxData(rxData[c*8 +: 8]), .rxReady(chRxReady[c]),
      .rxCount(rxCount[c*11 +: 11]), .rxArrive(arrive[c]), .rxError(rxError[c]),
      .serialIn(serialIn[c]), .serialOut(serialOut[c])
    );
  end

  // =====================================================
  // receive event of channel one; held off while serviced, so a
  // burst of bytes during service yields a single follow-up event
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pending <= 1'b0;
      awaitSvc <= 1'b0;
      svcPrev <= 1'b0;
      rx_arrival_event <= 1'b0;
    end else begin
      svcPrev <= serviceActive;
      rx_arrival_event <= 1'b0;
      if (serviceActive) begin
        awaitSvc <= 1'b0;
      end
      if (pending && rxEventEnable && !serviceActive && !awaitSvc) begin
        rx_arrival_event <= 1'b1;
        awaitSvc <= 1'b1;
        pending <= 1'b0;
      end
      // new arrivals and leftovers at service end win over the clear
      if (arrive[1] || (svcPrev && !serviceActive && rxCount[21:11] != 11'h000)) begin
        pending <= 1'b1;
      end
    end
  end

  chk_evt_hold: assert property (@(posedge sys_clk) disable iff (reset)
    serviceActive |=> !rx_arrival_event)
    else $error("event raised during service");
  // an already pending arrival fires one cycle sooner than a fresh one
  chk_evt_refire: assert property (@(posedge sys_clk) disable iff (reset)
    rxEventEnable && $fell(serviceActive) && rxCount[21:11] != 11'h000 && !awaitSvc
    ##1 (rxEventEnable && !serviceActive) |-> ##[0:1] rx_arrival_event)
    else $error("no event after service with data left");
  chk_evt_arrive: assert property (@(posedge sys_clk) disable iff (reset)
    arrive[1] && rxEventEnable && !serviceActive && !awaitSvc && !rx_arrival_event
    ##1 (rxEventEnable && !serviceActive) |-> ##[0:1] rx_arrival_event)
    else $error("no event after arrival");
endmodule

// >>> hdl/sci_pkg.sv
// =====================================================
// shared constants of the serial channel block
package sci_pkg;
  // system clock rate in hertz
  localparam int unsigned SCI_CLK_HZ = 200_000_000;
  // width of all byte counts and configured depths
  localparam int SCI_CNT_W = 11;
  // largest configurable buffer depth
  localparam logic [10:0] SCI_MAX_DEPTH = 11'h400;
  // width of the per-bit clock divider
  localparam int SCI_DIV_W = 17;
  // protocol byte field positions
  localparam int SCI_P_BITS_LO = 0;
  localparam int SCI_P_STOP = 2;
  localparam int SCI_P_PAR_LO = 3;
  // parity codes
  localparam logic [1:0] SCI_PAR_EVEN = 2'h2;
  localparam logic [1:0] SCI_PAR_ODD = 2'h3;
  // values after reset: 9600 baud, protocol 3 (8-N-1)
  localparam logic [3:0] SCI_RST_BAUD = 4'h2;
  localparam logic [7:0] SCI_RST_PROTO = 8'h03;
  localparam logic [3:0] SCI_NUM_RATES = 4'hb;

  // baud index to clock cycles per bit; an unknown index falls back to 9600
  function automatic logic [16:0] sci_bit_div(input logic [3:0] sel);
    int unsigned rate;
    case (sel)
      4'h0: rate = 2400;
      4'h1: rate = 4800;
      4'h3: rate = 14400;
      4'h4: rate = 19200;
      4'h5: rate = 28800;
      4'h6: rate = 38400;
      4'h7: rate = 57600;
      4'h8: rate = 76800;
      4'h9: rate = 115200;
      4'ha: rate = 230400;
      default: rate = 9600;
    endcase
    return 17'(SCI_CLK_HZ / rate);
  endfunction
endpackage

// >>> tb/sci_peer.sv
`timescale 1ns/1ps
// =====================================================
// remote serial device: frames bytes onto the line and decodes frames off it
module sci_peer #(
  parameter int BIT = 868
) (
  input wire logic sys_clk,
  input wire logic lineIn,
  output logic lineOut
);
  // the line rests at mark level between frames
  initial lineOut = 1'b1;

  // bit timing is paced on the falling edge, like all other stimulus
  task automatic hold(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // send one frame; badPar flips the parity bit to provoke a receive error
  task automatic send(input logic [7:0] d, input int nb, input logic [1:0] par,
                      input int nStop, input logic badPar);
    logic p;
    @(negedge sys_clk);
    p = ^(d & 8'((1 << nb) - 1)) ^ par[0] ^ badPar;
    lineOut = 1'b0;
    hold(BIT);
    for (int i = 0; i < nb; i++) begin
      lineOut = d[i];
      hold(BIT);
    end
    // parity only when even or odd is selected
    if (par[1]) begin
      lineOut = p;
      hold(BIT);
    end
    lineOut = 1'b1;
    hold(BIT * nStop);
  endtask

  // receive one frame at mid bit; ok is low on a bad start, parity or stop
  task automatic recv(input int nb, input logic [1:0] par, input int nStop,
                      output logic [7:0] d, output logic ok);
    d = 8'h00;
    @(negedge lineIn);
    hold(BIT / 2);
    ok = (lineIn === 1'b0);
    for (int i = 0; i < nb; i++) begin
      hold(BIT);
      d[i] = lineIn;
    end
    if (par[1]) begin
      hold(BIT);
      ok &= (lineIn === (^d ^ par[0]));
    end
    // every stop bit must be high, not only the first
    for (int s = 0; s < nStop; s++) begin
      hold(BIT);
      ok &= (lineIn === 1'b1);
    end
  endtask
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ps
`define CHK(nm, exp, act) \
  begin \
    tests_run++; \
    if ((act) !== (exp)) begin \
      fails++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, act); \
    end \
  end

// =====================================================
// bench for the two-channel serial block
module tb;
  localparam int BIT = 868; // cycles per bit at 230400 baud
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] serial_runtime_reconfigure = 2'h0;
  logic [7:0] cfgBaud = 8'h00;
  logic [15:0] cfgProto = 16'h0000;
  logic [21:0] cfgRxDepth = 22'h000000;
  logic [21:0] cfgTxDepth = 22'h000000;
  logic [1:0] cfgDone, txReady, txDrop, rxValid, rxError, serialOut;
  logic [1:0] txValid = 2'h0;
  logic [1:0] rxReady = 2'h0;
  logic [15:0] txData = 16'h0000;
  logic [15:0] rxData;
  logic [21:0] txFree, rxCount;
  logic monitorMode = 1'b0;
  logic monTxValid = 1'b0;
  logic [7:0] monTxData = 8'h00;
  logic monRxValid;
  logic monRxReady = 1'b0;
  logic rxEventEnable = 1'b0;
  logic serviceActive = 1'b0;
  logic rx_arrival_event;
  wire logic [1:0] serialIn;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  int evtCount = 0; // event pulses seen
  int errCount = 0; // receive error pulses seen on channel one
  int err0Count = 0; // receive error pulses seen on channel zero
  logic [7:0] a, b;
  logic okA, okB;

  always #2.5 sys_clk = ~sys_clk;

  sci_serial dut_u (
    .sys_clk(sys_clk), .reset(reset),
    .serial_runtime_reconfigure(serial_runtime_reconfigure),
    .cfgBaud(cfgBaud), .cfgProto(cfgProto), .cfgRxDepth(cfgRxDepth),
    .cfgTxDepth(cfgTxDepth), .cfgDone(cfgDone), .txValid(txValid), .txData(txData),
    .txReady(txReady), .txDrop(txDrop), .txFree(txFree), .rxValid(rxValid),
    .rxData(rxData), .rxReady(rxReady), .rxCount(rxCount), .rxError(rxError),
    .monitorMode(monitorMode), .monTxValid(monTxValid), .monTxData(monTxData),
    .monRxValid(monRxValid), .monRxReady(monRxReady), .rxEventEnable(rxEventEnable),
    .serviceActive(serviceActive), .rx_arrival_event(rx_arrival_event),
    .serialIn(serialIn), .serialOut(serialOut)
  );
  sci_peer #(.BIT(BIT)) peer0_u (.sys_clk(sys_clk), .lineIn(serialOut[0]),
    .lineOut(serialIn[0]));
  sci_peer #(.BIT(BIT)) peer1_u (.sys_clk(sys_clk), .lineIn(serialOut[1]),
    .lineOut(serialIn[1]));

  // pulse counters, and a ceiling well above the planned run of about 60k cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (rx_arrival_event === 1'b1) evtCount++;
    if (rxError[1] === 1'b1) errCount++;
    if (rxError[0] === 1'b1) err0Count++;
    if (cycles == 80000) begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (fails == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // apply one channel configuration and see it take hold
  task automatic apply(input int c, input logic [7:0] p, input logic [10:0] td);
    @(negedge sys_clk);
    cfgBaud[c*4 +: 4] = 4'ha;
    cfgProto[c*8 +: 8] = p;
    cfgRxDepth[c*11 +: 11] = 11'h032;
    cfgTxDepth[c*11 +: 11] = td;
    serial_runtime_reconfigure[c] = 1'b1;
    @(negedge sys_clk);
    serial_runtime_reconfigure[c] = 1'b0;
    @(negedge sys_clk);
    `CHK("cfgDone", 1'b1, cfgDone[c])
    `CHK("txFree", (td > 11'h010) ? 11'h010 : td, txFree[c*11 +: 11])
  endtask

  // one transmit write, with the same-cycle drop flag judged
  task automatic wr(input int c, input logic [7:0] d, input logic drop);
    @(negedge sys_clk);
    txValid[c] = 1'b1;
    txData[c*8 +: 8] = d;
    #1;
    `CHK("txDrop", drop, txDrop[c])
    @(negedge sys_clk);
    txValid[c] = 1'b0;
  endtask

  // read one seven-bit byte from a channel buffer
  task automatic pop(input int c, input logic [6:0] d);
    @(negedge sys_clk);
    `CHK("rxValid", 1'b1, rxValid[c])
    `CHK("rxData", d, rxData[c*8 +: 7])
    rxReady[c] = 1'b1;
    @(negedge sys_clk);
    rxReady[c] = 1'b0;
  endtask

  task automatic waitEvt(input int lim);
    int base;
    base = evtCount;
    for (int i = 0; i < lim && evtCount == base; i++) @(negedge sys_clk);
  endtask

  // =====================================================
  // idle state after reset: no traffic is possible before configuration
  task automatic t_reset();
    `CHK("serialOut", 2'h3, serialOut)
    `CHK("cfgDone", 2'h0, cfgDone)
    `CHK("txReady", 2'h0, txReady)
    `CHK("event", 1'b0, rx_arrival_event)
    `CHK("rxCount", 22'h000000, rxCount)
  endtask

  // seven bits odd parity two stops; a one-byte limit forces a drop
  task automatic t_tx();
    apply(1, 8'h1e, 11'h001);
    fork
      begin
        peer1_u.recv(7, 2'h3, 2, a, okA);
        peer1_u.recv(7, 2'h3, 2, b, okB);
      end
      begin
        wr(1, 8'h55, 1'b0);
        repeat (4) @(negedge sys_clk);
        `CHK("txFree", 11'h001, txFree[21:11])
        wr(1, 8'h2a, 1'b0);
        wr(1, 8'h11, 1'b1);
        `CHK("txFree", 11'h000, txFree[21:11])
      end
    join
    `CHK("frame0", 8'h55, a)
    `CHK("frame0ok", 1'b1, okA)
    `CHK("frame1", 8'h2a, b)
    `CHK("frame1ok", 1'b1, okB)
  endtask

  // arrival event, held off during service, refired after service ends
  task automatic t_event();
    rxEventEnable = 1'b1;
    fork
      peer1_u.send(8'h33, 7, 2'h3, 2, 1'b0);
      waitEvt(12 * BIT);
    join
    `CHK("evtCount", 1, evtCount)
    `CHK("rxCount", 11'h001, rxCount[21:11])
    serviceActive = 1'b1;
    peer1_u.send(8'h4c, 7, 2'h3, 2, 1'b0);
    repeat (8) @(negedge sys_clk);
    `CHK("evtCount", 1, evtCount)
    `CHK("rxCount", 11'h002, rxCount[21:11])
    serviceActive = 1'b0;
    repeat (4) @(negedge sys_clk);
    `CHK("evtCount", 2, evtCount)
    pop(1, 7'h33);
    pop(1, 7'h4c);
    `CHK("rxCount", 11'h000, rxCount[21:11])
  endtask

  // reconfigure to even parity while running, then send a wrong parity bit
  task automatic t_error();
    apply(1, 8'h13, 11'h028);
    peer1_u.send(8'h96, 8, 2'h2, 1, 1'b1);
    repeat (4) @(negedge sys_clk);
    `CHK("errCount", 1, errCount)
    `CHK("rxCount", 11'h000, rxCount[21:11])
  endtask

  // monitor path on channel zero, both directions at once, eight bits odd parity
  task automatic t_monitor();
    monitorMode = 1'b1;
    apply(0, 8'h1b, 11'h028);
    fork
      peer0_u.recv(8, 2'h3, 1, a, okA);
      peer0_u.send(8'hc3, 8, 2'h3, 1, 1'b0);
      begin
        @(negedge sys_clk);
        monTxValid = 1'b1;
        monTxData = 8'h5a;
        #1;
        `CHK("txDrop0", 1'b0, txDrop[0])
        @(negedge sys_clk);
        monTxValid = 1'b0;
      end
    join
    repeat (4) @(negedge sys_clk);
    `CHK("monFrame", 8'h5a, a)
    `CHK("monFrameOk", 1'b1, okA)
    `CHK("monRxValid", 1'b1, monRxValid)
    `CHK("rxValid0", 1'b0, rxValid[0])
    `CHK("rxData0", 8'hc3, rxData[7:0])
    `CHK("err0Count", 0, err0Count)
    monRxReady = 1'b1;
    @(negedge sys_clk);
    monRxReady = 1'b0;
    @(negedge sys_clk);
    `CHK("rxCount0", 11'h000, rxCount[10:0])
  endtask

  initial begin
    repeat (16) @(negedge sys_clk);
    reset = 1'b0;
    @(negedge sys_clk);
    t_reset();
    t_tx();
    t_event();
    t_error();
    t_monitor();
    tally_and_finish();
  end
endmodule
